/* rtl/spi_eeprom_pkg.sv */
// constants shared by the serial eeprom device end and host end
package spi_eeprom_pkg;
   localparam int          CLK_HZ           = 10_000_000;
   localparam int          WRITE_TIME_MS    = 5;
   localparam int          WRITE_CYCLES     = WRITE_TIME_MS * (CLK_HZ / 1000);
   localparam int          POWERUP_READ_MS  = 1;
   localparam int          POWERUP_WRITE_MS = 1;
   localparam int          POWERUP_MS       = (POWERUP_READ_MS > POWERUP_WRITE_MS) ? POWERUP_READ_MS
                                                                                 : POWERUP_WRITE_MS;
   localparam int          POWERUP_CYCLES   = POWERUP_MS * (CLK_HZ / 1000);
   localparam int          HALF_SCK_CYCLES  = 4;
   localparam int          ADDR_W           = 14;
   localparam int          PAGE_W           = 6;
   localparam int          FIFO_DEPTH       = 8;
   localparam int          FIFO_WIDTH       = 9;
   localparam logic [7:0]  OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0]  OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0]  OP_READ_STATUS   = 8'h05;
   localparam logic [7:0]  OP_WRITE_STATUS  = 8'h01;
   localparam logic [7:0]  OP_READ_DATA     = 8'h03;
   localparam logic [7:0]  OP_WRITE_DATA    = 8'h02;
   localparam int          SR_BUSY_BIT      = 0;
   localparam int          SR_WEL_BIT       = 1;
   localparam int          SR_BP0_BIT       = 2;
   localparam int          SR_BP1_BIT       = 3;
   localparam int          SR_HW_PROTECT_ENABLE_BIT = 7;
   localparam logic [7:0]  SR_RESET         = 8'h00;
endpackage : spi_eeprom_pkg

/* rtl/spi_eeprom_if.sv */
// pin bundle between host and eeprom device
`timescale 1ns/100ps
interface spi_eeprom_if;
   logic sck;
   logic cs_n;
   logic si;
   logic hold_n;
   logic wp_n;
   logic so;
   logic so_oe;
   logic so_line;

   // output pin is pulled high when released
   assign so_line = so_oe ? so : 1'b1;

   modport host   (output sck, cs_n, si, hold_n, wp_n, input so_line);
   modport device (input sck, cs_n, si, hold_n, wp_n, output so, so_oe);
endinterface : spi_eeprom_if

/* rtl/sync_fifo.sv */
// synchronous valid/ready fifo
`timescale 1ns/100ps
module sync_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_sys_i,   // system clock
   input  wire logic             rst_i,       // async reset, high
   input  wire logic [WIDTH-1:0] in_data_i,   // write word
   input  wire logic             in_valid_i,  // write request
   output logic                  in_ready_o,  // not full
   output logic      [WIDTH-1:0] out_data_o,  // head word
   output logic                  out_valid_o, // not empty
   input  wire logic             out_ready_i  // pop request
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready_o  = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_ready_i & out_valid_o;
   assign out_data_o  = mem[rd_ptr];

   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : sync_fifo

/* rtl/spi_eeprom_host.sv */
// host end: powers up, frames bytes from a fifo onto the serial pins
`timescale 1ns/100ps
module spi_eeprom_host #(
   parameter int POWERUP_CYCLES = spi_eeprom_pkg::POWERUP_CYCLES,
   parameter int HALF_CYCLES    = spi_eeprom_pkg::HALF_SCK_CYCLES,
   parameter int FIFO_DEPTH     = spi_eeprom_pkg::FIFO_DEPTH
) (
   input  wire logic       clk_sys_i,  // system clock
   input  wire logic       rst_i,      // async reset, high
   spi_eeprom_if.host      link,       // serial pins
   input  wire logic [7:0] tx_data_i,  // byte to send
   input  wire logic       tx_last_i,  // byte closes the frame
   input  wire logic       tx_valid_i, // byte offered
   output logic            tx_ready_o, // fifo has room
   input  wire logic       pause_i,    // request a pause
   input  wire logic       wp_n_i,     // protect pin level
   output logic      [7:0] rx_data_o,  // byte received
   output logic            rx_valid_o, // pulse per byte
   output logic            ready_o,    // power-up wait over
   output logic            busy_o      // frame open
);
   typedef enum {st_powerup, st_idle, st_fetch, st_low, st_high, st_end, st_gap} host_state_t;

   localparam int PW = $clog2(POWERUP_CYCLES + 1);
   localparam int HW = $clog2(HALF_CYCLES + 1);

   host_state_t state;
   logic [PW-1:0] pu_cnt;
   logic [HW-1:0] cnt;
   logic [2:0]    bit_idx;
   logic [7:0]    tx_sh;
   logic [6:0]    rx_sh;
   logic          last;
   logic          so_meta;
   logic          so_s;
   logic [8:0]    fifo_data;
   logic          fifo_valid;
   logic          fifo_pop;
   logic          half_done;

   sync_fifo #(.WIDTH(spi_eeprom_pkg::FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_i       (rst_i),
      .in_data_i   ({tx_last_i, tx_data_i}),
      .in_valid_i  (tx_valid_i),
      .in_ready_o  (tx_ready_o),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop)
   );

   // data is drained only between bytes, so a stalled frame holds the clock low
   assign fifo_pop  = (state == st_idle || state == st_fetch) && fifo_valid;
   assign half_done = (cnt == HW'(HALF_CYCLES - 1));
   assign ready_o   = (state != st_powerup);
   assign busy_o    = ~link.cs_n;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         so_meta <= 1'b1;
         so_s    <= 1'b1;
      end else begin
         so_meta <= link.so_line;
         so_s    <= so_meta;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         link.wp_n <= 1'b1;
      end else begin
         link.wp_n <= wp_n_i;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state      <= st_powerup;
         pu_cnt     <= '0;
         cnt        <= '0;
         bit_idx    <= '0;
         tx_sh      <= '0;
         rx_sh      <= '0;
         last       <= 1'b0;
         link.sck   <= 1'b0;
         link.cs_n  <= 1'b1;
         link.si    <= 1'b0;
         link.hold_n <= 1'b1;
         rx_data_o  <= '0;
         rx_valid_o <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         case (state)
            st_powerup: begin
               if (pu_cnt == PW'(POWERUP_CYCLES - 1)) begin
                  state <= st_idle;
               end else begin
                  pu_cnt <= pu_cnt + 1'b1;
               end
            end
            st_idle, st_fetch: begin
               if (fifo_valid) begin
                  link.cs_n <= 1'b0;
                  tx_sh     <= fifo_data[7:0];
                  last      <= fifo_data[8];
                  link.si   <= fifo_data[7];
                  bit_idx   <= '0;
                  cnt       <= '0;
                  state     <= st_low;
               end
            end
            st_low: begin
               // pause edges only happen here, with the clock low
               if (pause_i) begin
                  link.hold_n <= 1'b0;
               end else if (!link.hold_n) begin
                  link.hold_n <= 1'b1;
               end else if (half_done) begin
                  link.sck <= 1'b1;
                  cnt      <= '0;
                  state    <= st_high;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            st_high: begin
               if (half_done) begin
                  // sample late in the high phase to cover both synchroniser delays
                  link.sck <= 1'b0;
                  cnt      <= '0;
                  rx_sh    <= {rx_sh[5:0], so_s};
                  if (bit_idx == 3'd7) begin
                     rx_data_o  <= {rx_sh, so_s};
                     rx_valid_o <= 1'b1;
                     state      <= last ? st_end : st_fetch;
                  end else begin
                     bit_idx <= bit_idx + 1'b1;
                     tx_sh   <= {tx_sh[6:0], 1'b0};
                     link.si <= tx_sh[6];
                     state   <= st_low;
                  end
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            st_end: begin
               if (half_done) begin
                  link.cs_n <= 1'b1;
                  cnt       <= '0;
                  state     <= st_gap;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            st_gap: begin
               if (half_done) begin
                  state <= st_idle;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            default: state <= st_idle;
         endcase
      end
   end
endmodule : spi_eeprom_host

/* rtl/spi_eeprom_device.sv */
// device end: serial eeprom target sampling the pins with the system clock
`timescale 1ns/100ps
module spi_eeprom_device #(
   parameter int WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLES,
   parameter int ADDR_W       = spi_eeprom_pkg::ADDR_W,
   parameter int PAGE_W       = spi_eeprom_pkg::PAGE_W
) (
   input  wire logic  clk_sys_i, // system clock
   input  wire logic  rst_i,     // async reset, high
   spi_eeprom_if.device link,    // serial pins
   output logic       busy_o,    // internal write running
   output logic [7:0] status_o,  // status byte
   output logic       standby_o  // deselected and idle
);
   typedef enum {st_opcode, st_addr_hi, st_addr_lo, st_read, st_write, st_status_out,
                 st_status_in, st_status_done, st_done, st_ignore} dev_state_t;

   localparam int TW = $clog2(WRITE_CYCLES + 1);
   localparam int PD = 1 << PAGE_W;

   logic [7:0]        mem      [0:(1<<ADDR_W)-1];
   logic [7:0]        page_buf [0:PD-1];
   logic [PD-1:0]     page_mask;
   logic [ADDR_W-1:PAGE_W] page_base;
   logic [4:0]        meta;
   logic [4:0]        sync;
   logic [4:0]        prev;
   logic              sck_s, cs_s, si_s, hold_s, wp_s;
   logic              rise, fall, cs_rise, cs_fall;
   dev_state_t        state;
   logic [2:0]        bit_cnt;
   logic [6:0]        rx_sh;
   logic [7:0]        byte_in;
   logic              byte_done;
   logic [7:0]        opcode;
   logic [15:0]       addr;
   logic [7:0]        tx_sh;
   logic              out_en;
   logic              out_arm;
   logic [7:0]        wrsr_val;
   logic              wel, hw_protect_enable_bit, busy, commit;
   logic [1:0]        bp;
   logic [TW-1:0]     timer;
   logic [7:0]        status_byte;
   logic              hw_protect;
   logic              end_write;

   function automatic dev_state_t decode_op(input logic [7:0] op, input logic is_busy);
      if (is_busy) begin
         return (op == spi_eeprom_pkg::OP_READ_STATUS) ? st_status_out : st_ignore;
      end
      case (op)
         spi_eeprom_pkg::OP_WRITE_ENABLE,
         spi_eeprom_pkg::OP_WRITE_DISABLE: return st_done;
         spi_eeprom_pkg::OP_READ_STATUS:   return st_status_out;
         spi_eeprom_pkg::OP_WRITE_STATUS:  return st_status_in;
         spi_eeprom_pkg::OP_READ_DATA,
         spi_eeprom_pkg::OP_WRITE_DATA:    return st_addr_hi;
         default:                          return st_ignore;
      endcase
   endfunction : decode_op

   function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [1:0] b);
      case (b)
         2'h1:    return (a[ADDR_W-1:ADDR_W-2] == 2'h3);
         2'h2:    return a[ADDR_W-1];
         2'h3:    return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : is_protected

   // pins come from another domain; the first stage feeds only the second
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= 5'h1E;
         sync <= 5'h1E;
         prev <= 5'h1E;
      end else begin
         meta <= {link.cs_n, link.hold_n, link.wp_n, link.si, link.sck};
         sync <= meta;
         prev <= sync;
      end
   end

   assign {cs_s, hold_s, wp_s, si_s, sck_s} = sync;
   // clock edges count only while selected and not paused
   assign rise      = ~cs_s & hold_s & sck_s & ~prev[0];
   assign fall      = ~cs_s & hold_s & ~sck_s & prev[0];
   assign cs_rise   = cs_s & ~prev[4];
   assign cs_fall   = ~cs_s & prev[4];
   assign byte_in   = {rx_sh, si_s};
   assign byte_done = rise & (bit_cnt == 3'd7);
   assign hw_protect = ~wp_s & hw_protect_enable_bit;
   assign end_write = busy & (timer == TW'(WRITE_CYCLES - 1));

   always_comb begin
      status_byte = spi_eeprom_pkg::SR_RESET;
      status_byte[spi_eeprom_pkg::SR_BUSY_BIT] = busy;
      status_byte[spi_eeprom_pkg::SR_WEL_BIT]  = wel;
      status_byte[spi_eeprom_pkg::SR_BP0_BIT]  = bp[0];
      status_byte[spi_eeprom_pkg::SR_BP1_BIT]  = bp[1];
      status_byte[spi_eeprom_pkg::SR_HW_PROTECT_ENABLE_BIT] = hw_protect_enable_bit;
   end

   assign status_o   = status_byte;
   assign busy_o     = busy;
   assign standby_o  = cs_s & ~busy;
   assign link.so_oe = out_en & ~cs_s & hold_s;

   // instruction framing; select high throws away any partial byte
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state    <= st_opcode;
         bit_cnt  <= '0;
         rx_sh    <= '0;
         opcode   <= '0;
         addr     <= '0;
         wrsr_val <= '0;
      end else if (cs_s) begin
         state   <= st_opcode;
         bit_cnt <= '0;
      end else if (rise) begin
         bit_cnt <= bit_cnt + 1'b1;
         rx_sh   <= byte_in[6:0];
         if (bit_cnt == 3'd7) begin
            case (state)
               st_opcode: begin
                  opcode <= byte_in;
                  state  <= decode_op(byte_in, busy);
               end
               st_addr_hi: begin
                  addr[15:8] <= byte_in;
                  state      <= st_addr_lo;
               end
               st_addr_lo: begin
                  if (opcode == spi_eeprom_pkg::OP_READ_DATA) begin
                     addr  <= {addr[15:8], byte_in} + 16'h0001;
                     state <= st_read;
                  end else begin
                     addr[7:0] <= byte_in;
                     state     <= st_write;
                  end
               end
               st_read: addr <= addr + 16'h0001;
               // page roll-over: only the low bits advance
               st_write: addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 1'b1;
               st_status_in: begin
                  wrsr_val <= byte_in;
                  state    <= st_status_done;
               end
               default: state <= state;
            endcase
         end
      end
   end

   // output shifter: loaded at byte end, shifted on falling edges
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         tx_sh    <= '0;
         link.so  <= 1'b0;
         out_en   <= 1'b0;
         out_arm  <= 1'b0;
      end else if (cs_s) begin
         out_en  <= 1'b0;
         out_arm <= 1'b0;
      end else if (byte_done) begin
         if ((state == st_opcode && decode_op(byte_in, busy) == st_status_out) || state == st_status_out) begin
            tx_sh   <= status_byte;
            out_arm <= 1'b1;
         end else if (state == st_addr_lo && opcode == spi_eeprom_pkg::OP_READ_DATA) begin
            tx_sh   <= mem[ADDR_W'({addr[15:8], byte_in})];
            out_arm <= 1'b1;
         end else if (state == st_read) begin
            tx_sh <= mem[addr[ADDR_W-1:0]];
         end
      end else if (fall) begin
         link.so <= tx_sh[7];
         tx_sh   <= {tx_sh[6:0], 1'b0};
         // drive only once the first bit is on the pin, never a stale one
         out_en  <= out_arm;
      end
   end

   // page loading; a running write keeps its buffer until committed
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         page_mask <= '0;
         page_base <= '0;
      end else if (cs_fall && !busy) begin
         page_mask <= '0;
      end else if (byte_done && state == st_write && wel && !is_protected(addr[ADDR_W-1:0], bp)) begin
         page_mask[addr[PAGE_W-1:0]] <= 1'b1;
         page_base                   <= addr[ADDR_W-1:PAGE_W];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (byte_done && state == st_write) begin
         page_buf[addr[PAGE_W-1:0]] <= byte_in;
      end
   end

   // commit at the end of the self-timed write
   always_ff @(posedge clk_sys_i) begin
      if (end_write && commit) begin
         for (int i = 0; i < PD; i++) begin
            if (page_mask[i]) begin
               mem[{page_base, PAGE_W'(i)}] <= page_buf[i];
            end
         end
      end
   end

   // status bits and write timer; writes start only on a clean select rise
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wel    <= 1'b0;
         hw_protect_enable_bit <= 1'b0;
         bp     <= '0;
         busy   <= 1'b0;
         commit <= 1'b0;
         timer  <= '0;
      end else if (busy) begin
         timer <= timer + 1'b1;
         if (end_write) begin
            busy <= 1'b0;
            wel  <= 1'b0;
         end
      end else if (cs_rise && bit_cnt == 3'd0) begin
         timer <= '0;
         case (state)
            st_done: wel <= (opcode == spi_eeprom_pkg::OP_WRITE_ENABLE);
            st_write: begin
               if (wel && page_mask != '0) begin
                  busy   <= 1'b1;
                  commit <= 1'b1;
               end
            end
            st_status_done: begin
               if (wel && !hw_protect) begin
                  hw_protect_enable_bit <= wrsr_val[spi_eeprom_pkg::SR_HW_PROTECT_ENABLE_BIT];
                  bp     <= {wrsr_val[spi_eeprom_pkg::SR_BP1_BIT], wrsr_val[spi_eeprom_pkg::SR_BP0_BIT]};
                  busy   <= 1'b1;
                  commit <= 1'b0;
               end
            end
            default: wel <= wel;
         endcase
      end
   end
endmodule : spi_eeprom_device

/* tb/spi_eeprom_checker.sv */
// assertions on the serial pins between the host and device ends
`timescale 1ns/100ps
module spi_eeprom_checker (
   input  wire logic clk_sys_i, // system clock
   input  wire logic rst_i,     // async reset, high
   input  wire logic sck,       // serial clock
   input  wire logic cs_n,      // select, active low
   input  wire logic si,        // data to device
   input  wire logic hold_n,    // pause, active low
   input  wire logic so,        // data from device
   input  wire logic so_oe      // device drives so
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   // the device sees pins through a synchroniser, so allow three cycles of lag
   sequence desel_s;
      cs_n [*4];
   endsequence
   sequence paused_s;
      !hold_n [*4];
   endsequence

   a_si_steady_high: assert property (!cs_n && $changed(si) |-> !sck)
      else $error("si moved while sck high");
   a_so_falling_only: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck)
      else $error("so moved while sck high");
   a_desel_tristate: assert property (desel_s |-> !so_oe)
      else $error("so driven while deselected");
   a_sck_in_frame: assert property (sck |-> !cs_n)
      else $error("sck high outside a frame");
   a_frame_close_gap: assert property ($rose(cs_n) |=> cs_n [*3])
      else $error("select reopened too soon");
   a_pause_tristate: assert property (paused_s |-> !so_oe)
      else $error("so driven while paused");
   a_hold_sck_low: assert property ($changed(hold_n) |-> !sck && !$past(sck))
      else $error("pause edge with sck high");
   a_pause_freezes: assert property (!hold_n && !$past(hold_n) |-> !sck && $stable(si))
      else $error("transfer moved while paused");
endmodule : spi_eeprom_checker

/* tb/tb_top.sv */
// self-checking bench: host and device ends joined over the serial pins
`timescale 1ns/100ps
module tb_top;
   localparam int WR = 1000;
   logic        clk_sys_i;
   logic        rst_i;
   logic [7:0]  tx_data;
   logic        tx_last;
   logic        tx_valid;
   logic        tx_ready;
   logic        pause;
   logic        wp_n;
   logic [7:0]  rx_data;
   logic        rx_valid;
   logic        ready;
   logic        hbusy;
   logic        dbusy;
   logic [7:0]  status;
   logic        standby;
   logic [7:0]  exp_q [$];
   logic [7:0]  d0;
   logic [7:0]  d1;
   logic [15:0] lfsr = 16'hA47F;
   logic [8:0]  tv [3] = '{9'h180, 9'h08C, 9'h100};
   logic [7:0]  ev [3] = '{8'h80, 8'h80, 8'h00};
   int          err_count = 0;
   int          samples_checked = 0;
   int          bcnt = 0;
   int          cyc = 0;

   spi_eeprom_if link_i ();
   spi_eeprom_host #(.POWERUP_CYCLES(50), .HALF_CYCLES(6), .FIFO_DEPTH(8)) spi_eeprom_host_i (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link_i.host), .tx_data_i(tx_data), .tx_last_i(tx_last),
      .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .pause_i(pause), .wp_n_i(wp_n), .rx_data_o(rx_data),
      .rx_valid_o(rx_valid), .ready_o(ready), .busy_o(hbusy));
   spi_eeprom_device #(.WRITE_CYCLES(WR)) spi_eeprom_device_i (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link_i.device), .busy_o(dbusy), .status_o(status),
      .standby_o(standby));
   spi_eeprom_checker spi_eeprom_checker_i (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sck(link_i.sck), .cs_n(link_i.cs_n), .si(link_i.si),
      .hold_n(link_i.hold_n), .so(link_i.so), .so_oe(link_i.so_oe));

   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask : check_byte

   task automatic check_flag(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : check_flag

   function automatic logic [7:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction : rnd

   // valid stays up between bytes so it is never assigned twice in one step
   task automatic put(input logic [7:0] d, input logic l, input logic [7:0] e);
      tx_data  <= d;
      tx_last  <= l;
      tx_valid <= 1'b1;
      exp_q.push_back(e);
      do @(negedge clk_sys_i); while (tx_ready !== 1'b1);
      @(posedge clk_sys_i);
   endtask : put

   task automatic frame(input logic [7:0] b [$], input logic [7:0] e [$]);
      foreach (b[i]) put(b[i], i == b.size() - 1, e[i]);
      tx_valid <= 1'b0;
      @(posedge clk_sys_i);
   endtask : frame

   // settle twice: the device busy starts a few cycles after select rises
   task automatic wait_done();
      repeat (2) begin
         for (int i = 0; i < 5000 && (exp_q.size() != 0 || hbusy !== 1'b0 || dbusy !== 1'b0); i++)
            @(posedge clk_sys_i);
         repeat (10) @(posedge clk_sys_i);
      end
   endtask : wait_done

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   always @(posedge clk_sys_i) begin
      cyc <= rst_i ? 0 : cyc + 1;
      if (rx_valid === 1'b1) begin
         if (exp_q.size() == 0) check_flag(1'b1, 1'b0);
         else check_byte(rx_data, exp_q.pop_front());
      end
      if (dbusy === 1'b1) bcnt <= bcnt + 1;
      else if (bcnt != 0) begin
         check_flag(bcnt >= WR - 4 && bcnt <= WR, 1'b1);
         bcnt <= 0;
      end
   end

   initial begin
      repeat (40000) @(posedge clk_sys_i);
      err_count++;
      finish_test();
   end

   initial begin
      rst_i    = 1'b1;
      tx_data  = 8'h00;
      tx_last  = 1'b0;
      tx_valid = 1'b0;
      pause    = 1'b0;
      wp_n     = 1'b1;
      repeat (12) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      d0 = rnd();
      d1 = rnd();
      frame('{8'h06}, '{8'hFF});
      frame('{8'h02, 8'h00, 8'h10, d0, d1}, '{5{8'hFF}});
      frame('{8'h05, 8'h00}, '{8'hFF, 8'h03});
      @(negedge clk_sys_i);
      check_flag(tx_ready, 1'b0);
      while (link_i.cs_n !== 1'b0) @(posedge clk_sys_i);
      check_flag(cyc >= 50, 1'b1);
      frame('{8'h06}, '{8'hFF});
      wait_done();
      frame('{8'h06}, '{8'hFF});
      frame('{8'h04}, '{8'hFF});
      frame('{rnd() | 8'h80}, '{8'hFF});
      frame('{8'h05, 8'h00}, '{8'hFF, 8'h00});
      wait_done();
      check_flag(standby, 1'b1);
      frame('{8'h03, 8'h00, 8'h10, rnd(), rnd()}, '{8'hFF, 8'hFF, 8'hFF, d0, d1});
      repeat (150) @(posedge clk_sys_i);
      pause <= 1'b1;
      repeat (40) @(posedge clk_sys_i);
      pause <= 1'b0;
      wait_done();
      for (int k = 0; k < 3; k++) begin
         wp_n <= tv[k][8];
         frame('{8'h06}, '{8'hFF});
         frame('{8'h01, tv[k][7:0]}, '{8'hFF, 8'hFF});
         wait_done();
         check_byte(status & 8'hFC, ev[k]);
      end
      check_flag(exp_q.size() == 0, 1'b1);
      finish_test();
   end
endmodule : tb_top
